// [hw/bre_ecc_ram.sv]
// Notes on behaviour
// [R1] User injects faults only in decode-only mode
// [R2] Single flipped bit corrected, single flag raised
// [R3] Two flipped bits flagged double, left uncorrected
// [R4] Encode-only write generates check bits internally
// [R5] Generated check bits shown; full word stored
// [R6] User flips bits, rewrites word decode-only
// [R7] Check output updates on the write edge
// [R8] Flags come direct or via output register
// [R9] Outputs in latch or register mode
// [R10] Queue function takes the lower port
// [R11] Decode-only stores user check bits unchanged
// [R12] Encode-only reads raw, never raise flags
// [R13] Register mode adds one read cycle
// [R14] Flags aligned with their data word
`timescale 1ns/10ps
module bre_ecc_ram
  import bre_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic write_enable_i,
  input wire logic [ADDR_W-1:0] write_addr_i,
  input wire logic [DATA_W-1:0] write_word_in_i,
  input wire logic [CHECK_W-1:0] write_check_bits_in_i,
  output logic [CHECK_W-1:0] generated_check_bits_out_o,
  input wire logic read_enable_i,
  input wire logic [ADDR_W-1:0] read_addr_i,
  output logic [DATA_W-1:0] read_word_out_o,
  output logic [CHECK_W-1:0] read_check_bits_out_o,
  output logic single_error_flag_o,
  output logic double_error_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and configuration
  logic [WORD_W-1:0] mem [DEPTH];
  logic [2:0] ctrl;
  logic ecc_wr_on;
  logic ecc_rd_on;
  logic out_reg_on;
  logic [1:0] err_status;
  logic [1:0] err_mask;
  logic [ADDR_W-1:0] last_err_addr;
  logic [15:0] sbe_count;
  logic [15:0] dbe_count;

  assign ecc_wr_on = ctrl[CTRL_ECC_WR_BIT];
  assign ecc_rd_on = ctrl[CTRL_ECC_RD_BIT];
  assign out_reg_on = ctrl[CTRL_OREG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  bre_code_if enc_code ();
  bre_encoder u_enc (
    .code(enc_code)
  );

  logic [CHECK_W-1:0] store_check;

  assign enc_code.data = write_word_in_i;

  always_comb begin
    if (ecc_wr_on) begin
      store_check = enc_code.check; // R4
    end else begin
      store_check = write_check_bits_in_i; // R11
    end
  end

  // Memory is not reset; its content is undefined until written
  always_ff @(posedge clk_i) begin
    if (write_enable_i) begin
      mem[write_addr_i] <= {store_check, write_word_in_i}; // R5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      generated_check_bits_out_o <= '0;
    end else if (write_enable_i && ecc_wr_on) begin
      generated_check_bits_out_o <= enc_code.check; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, decode and output stage
  bre_code_if dec_code ();
  bre_decoder u_dec (
    .code(dec_code)
  );

  logic [WORD_W-1:0] raw_word;
  logic [DATA_W-1:0] rd_data;
  logic [CHECK_W-1:0] rd_check;
  logic rd_sbe;
  logic rd_dbe;

  // Read-first: a read of the address being written sees the old word
  assign raw_word = mem[read_addr_i];
  assign dec_code.data = raw_word[DATA_W-1:0];
  assign dec_code.check = raw_word[WORD_W-1:DATA_W];

  always_comb begin
    if (ecc_rd_on) begin
      rd_data = dec_code.fixed_data; // R2
      rd_check = dec_code.fixed_check; // R2
      rd_sbe = dec_code.single_err; // R2
      rd_dbe = dec_code.double_err; // R3
    end else begin
      rd_data = raw_word[DATA_W-1:0]; // R12
      rd_check = raw_word[WORD_W-1:DATA_W]; // R12
      rd_sbe = 1'b0; // R12
      rd_dbe = 1'b0; // R12
    end
  end

  logic [DATA_W-1:0] pipe_data;
  logic [CHECK_W-1:0] pipe_check;
  logic pipe_sbe;
  logic pipe_dbe;
  logic pipe_valid;
  logic [ADDR_W-1:0] pipe_addr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_data <= '0;
      pipe_check <= '0;
      pipe_sbe <= 1'b0;
      pipe_dbe <= 1'b0;
      pipe_addr <= '0;
    end else if (read_enable_i) begin
      pipe_data <= rd_data;
      pipe_check <= rd_check;
      pipe_sbe <= rd_sbe;
      pipe_dbe <= rd_dbe;
      pipe_addr <= read_addr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_valid <= 1'b0;
    end else begin
      pipe_valid <= read_enable_i;
    end
  end

  logic load_out;
  logic [DATA_W-1:0] next_data;
  logic [CHECK_W-1:0] next_check;
  logic next_sbe;
  logic next_dbe;
  logic [ADDR_W-1:0] next_addr;

  // One select moves data, check bits and both flags together
  always_comb begin
    if (out_reg_on) begin
      load_out = pipe_valid; // R13
      next_data = pipe_data; // R9
      next_check = pipe_check; // R9
      next_sbe = pipe_sbe; // R8
      next_dbe = pipe_dbe; // R8
      next_addr = pipe_addr;
    end else begin
      load_out = read_enable_i; // R9
      next_data = rd_data; // R9
      next_check = rd_check; // R9
      next_sbe = rd_sbe; // R8
      next_dbe = rd_dbe; // R8
      next_addr = read_addr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_word_out_o <= '0;
      read_check_bits_out_o <= '0;
      single_error_flag_o <= 1'b0;
      double_error_flag_o <= 1'b0;
    end else if (load_out) begin
      read_word_out_o <= next_data;
      read_check_bits_out_o <= next_check;
      single_error_flag_o <= next_sbe; // R14
      double_error_flag_o <= next_dbe; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error events, statistics and interrupt
  logic [1:0] err_set;
  logic [1:0] err_clr;
  logic [1:0] mask_wr;
  logic wr_commit;
  logic [7:0] reg_ofs;

  assign reg_ofs = {wb_adr_i[7:2], 2'h0};
  // A write lands on the edge where the master sees ack high
  assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  function automatic logic reg_wr(input logic commit, input logic lane,
    input logic [7:0] at, input logic [7:0] ofs);
    return commit && lane && (at == ofs);
  endfunction

  assign err_set = {load_out & next_dbe, load_out & next_sbe};

  always_comb begin
    err_clr = 2'h0;
    mask_wr = 2'h0;
    if (reg_wr(wr_commit, wb_sel_i[0], reg_ofs, OFS_STATUS)) begin
      err_clr = wb_dat_i[1:0];
    end
    if (reg_wr(wr_commit, wb_sel_i[0], reg_ofs, OFS_MASK)) begin
      mask_wr = 2'h3;
    end
  end

  // A new error in the clearing cycle stays set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_status <= STATUS_RESET;
    end else begin
      err_status <= (err_status & ~err_clr) | err_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_mask <= MASK_RESET;
    end else if (mask_wr != 2'h0) begin
      err_mask <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_err_addr <= '0;
    end else if (err_set != 2'h0) begin
      last_err_addr <= next_addr;
    end
  end

  // Counters saturate so a storm of errors never wraps to a small value
  logic cnt_clr;
  assign cnt_clr = reg_wr(wr_commit, 1'h1, reg_ofs, OFS_ERR_COUNT);

  function automatic logic [15:0] sat_inc(input logic [15:0] c,
    input logic hit);
    if (hit && c != COUNT_MAX) begin
      return c + 16'h0001;
    end
    return c;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sbe_count <= '0;
      dbe_count <= '0;
    end else begin
      if (cnt_clr) begin
        sbe_count <= {15'h0000, err_set[STAT_SBE_BIT]};
        dbe_count <= {15'h0000, err_set[STAT_DBE_BIT]};
      end else begin
        sbe_count <= sat_inc(sbe_count, err_set[STAT_SBE_BIT]);
        dbe_count <= sat_inc(dbe_count, err_set[STAT_DBE_BIT]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(err_status & err_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr(wr_commit, wb_sel_i[0], reg_ofs, OFS_CTRL)) begin
      ctrl <= wb_dat_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, dropped after one
  bre_bus_state_t bus_state;
  logic [31:0] reg_rdata;

  always_comb begin
    case (reg_ofs)
      OFS_CTRL: reg_rdata = {29'h00000000, ctrl};
      OFS_STATUS: reg_rdata = {30'h00000000, err_status};
      OFS_MASK: reg_rdata = {30'h00000000, err_mask};
      OFS_ERR_ADDR: reg_rdata = {23'h000000, last_err_addr};
      OFS_ERR_COUNT: reg_rdata = {dbe_count, sbe_count};
      OFS_GEN_CHECK: reg_rdata = {24'h000000, generated_check_bits_out_o};
      default: reg_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state <= BUS_ACK;
            wb_ack_o <= 1'b1;
            wb_dat_o <= reg_rdata;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          bus_state <= BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // bre_ecc_ram

// [shared/bre_pkg.sv]
package bre_pkg;

  localparam int DATA_W = 64;
  localparam int CHECK_W = 8;
  localparam int HAM_W = 7;
  localparam int WORD_W = 72;
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;
  localparam int LAST_POS = 71;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h0C;
  localparam logic [7:0] OFS_ERR_COUNT = 8'h10;
  localparam logic [7:0] OFS_GEN_CHECK = 8'h14;

  localparam int CTRL_ECC_WR_BIT = 0;
  localparam int CTRL_ECC_RD_BIT = 1;
  localparam int CTRL_OREG_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h3;

  localparam int STAT_SBE_BIT = 0;
  localparam int STAT_DBE_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  typedef enum logic {BUS_IDLE, BUS_ACK} bre_bus_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Code word position of data bit idx; powers of two hold check bits
  function automatic logic [HAM_W-1:0] bre_data_pos(input int idx);
    int n;
    logic [HAM_W-1:0] pos;
    n = 0;
    pos = 7'h00;
    for (int q = 3; q <= LAST_POS; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (n == idx) pos = q[HAM_W-1:0];
        n++;
      end
    end
    return pos;
  endfunction

  // Hamming part of the check bits, shared by encoder and decoder
  function automatic logic [HAM_W-1:0] bre_hamming(
    input logic [DATA_W-1:0] d
  );
    logic [HAM_W-1:0] h;
    logic [HAM_W-1:0] pos;
    h = 7'h00;
    for (int i = 0; i < DATA_W; i++) begin
      pos = bre_data_pos(i);
      for (int k = 0; k < HAM_W; k++) begin
        if (pos[k]) h[k] = h[k] ^ d[i];
      end
    end
    return h;
  endfunction

endpackage

// [shared/bre_code_if.sv]
`timescale 1ns/10ps
interface bre_code_if;
  import bre_pkg::*;
  logic [DATA_W-1:0] data;
  logic [CHECK_W-1:0] check;
  logic [DATA_W-1:0] fixed_data;
  logic [CHECK_W-1:0] fixed_check;
  logic single_err;
  logic double_err;
  modport encoder (input data, output check);
  modport decoder (input data, input check, output fixed_data,
    output fixed_check, output single_err, output double_err);
endinterface

// [hw/bre_encoder.sv]
`timescale 1ns/10ps
module bre_encoder
  import bre_pkg::*;
(
  bre_code_if.encoder code
);
  logic [HAM_W-1:0] ham;

  // Overall parity covers data and Hamming bits, giving double detection
  assign ham = bre_hamming(code.data);
  assign code.check = {^{code.data, ham}, ham};
endmodule // bre_encoder

// [hw/bre_decoder.sv]
`timescale 1ns/10ps
module bre_decoder
  import bre_pkg::*;
(
  bre_code_if.decoder code
);
  logic [HAM_W-1:0] syn;
  logic overall;
  logic hit;
  logic [DATA_W-1:0] flip;
  logic [CHECK_W-1:0] flip_chk;

  always_comb begin
    syn = bre_hamming(code.data) ^ code.check[HAM_W-1:0];
    overall = ^{code.check, code.data};
    flip = '0;
    flip_chk = '0;
    hit = (syn == 7'h00);
    flip_chk[CHECK_W-1] = (syn == 7'h00);
    for (int i = 0; i < DATA_W; i++) begin
      if (bre_data_pos(i) == syn) begin
        flip[i] = 1'b1;
        hit = 1'b1;
      end
    end
    for (int k = 0; k < HAM_W; k++) begin
      if (syn == (7'h01 << k)) begin
        flip_chk[k] = 1'b1;
        hit = 1'b1;
      end
    end
    // A syndrome beyond the last position cannot be one flip
    code.single_err = overall & hit;
    code.double_err = (syn != 7'h00) & (~overall | ~hit);
    code.fixed_data = code.single_err ? code.data ^ flip : code.data;
    code.fixed_check = code.single_err ? code.check ^ flip_chk : code.check;
  end
endmodule // bre_decoder

// [testbench/bre_ecc_ram_monitor.sv]
`timescale 1ns/10ps
module bre_ecc_ram_monitor
  import bre_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic write_enable_i,
  input wire logic [CHECK_W-1:0] generated_check_bits_out_o,
  input wire logic read_enable_i,
  input wire logic [DATA_W-1:0] read_word_out_o,
  input wire logic [CHECK_W-1:0] read_check_bits_out_o,
  input wire logic single_error_flag_o,
  input wire logic double_error_flag_o
);
  logic [2:0] ctrl;
  logic [1:0] mask;
  logic wr_ok;
  assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  ////////////////////////////////////////////////////////////////////////////
  // Mirror of CTRL and MASK, taken at the same ack edge as the slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
    end else if (wr_ok && wb_adr_i[7:2] == OFS_CTRL[7:2]) begin
      ctrl <= wb_dat_i[2:0];
    end else if (wr_ok && wb_adr_i[7:2] == OFS_MASK[7:2]) begin
      mask <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("bus request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  check_hold_a: assert property (
    !($past(write_enable_i) && $past(ctrl[0]))
    |-> $stable(generated_check_bits_out_o)) else $error("check out moved");
  latch_hold_a: assert property (!$past(ctrl[2])
    && !$past(ctrl[2], 2) && !$past(read_enable_i)
    |-> $stable(read_word_out_o)
    && $stable(single_error_flag_o) && $stable(double_error_flag_o))
    else $error("latch output moved without read");
  reg_hold_a: assert property ($past(ctrl[2]) && $past(ctrl[2], 2)
    && !$past(read_enable_i, 2) |-> $stable(read_word_out_o)
    && $stable(read_check_bits_out_o)) else $error("register output early");
  raw_read_a: assert property ($past(read_enable_i) && !$past(ctrl[1])
    && !$past(ctrl[2]) |-> !single_error_flag_o && !double_error_flag_o)
    else $error("flag with decoder off");
  flag_excl_a: assert property (
    !(single_error_flag_o && double_error_flag_o))
    else $error("both flags high");
  irq_mask_a: assert property (irq_o |-> $past(mask) != 2'h0)
    else $error("irq while masked");
  irq_event_a: assert property ($rose(single_error_flag_o) && mask[0]
    |-> ##[0:2] irq_o) else $error("irq missing");
endmodule // bre_ecc_ram_monitor

bind bre_ecc_ram bre_ecc_ram_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .irq_o,
  .write_enable_i, .generated_check_bits_out_o, .read_enable_i,
  .read_word_out_o, .read_check_bits_out_o, .single_error_flag_o,
  .double_error_flag_o);

// [testbench/bre_fabric_model.sv]
`timescale 1ns/10ps
module bre_fabric_model
  import bre_pkg::*;
(
  input wire logic clk_i,
  output logic write_enable_o,
  output logic [ADDR_W-1:0] write_addr_o,
  output logic [DATA_W-1:0] write_word_o,
  output logic [CHECK_W-1:0] write_check_o,
  output logic read_enable_o,
  output logic [ADDR_W-1:0] read_addr_o
);
  initial begin
    write_enable_o = 1'h0;
    write_addr_o = '0;
    write_word_o = '0;
    write_check_o = '0;
    read_enable_o = 1'h0;
    read_addr_o = '0;
  end
  // Whole word per write, check bits always on the lines beside the data
  task automatic write_word(input logic [ADDR_W-1:0] a,
    input logic [WORD_W-1:0] w);
    @(posedge clk_i);
    write_enable_o <= 1'h1;
    write_addr_o <= a;
    {write_check_o, write_word_o} <= w;
    @(posedge clk_i);
    write_enable_o <= 1'h0;
    // Released lines show the inverse, so a stale copy is never read
    {write_check_o, write_word_o} <= ~w;
  endtask
  // Plain memory use only: no queue shares this site, the lower port is free
  task automatic read_word(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    read_enable_o <= 1'h1;
    read_addr_o <= a;
    @(posedge clk_i);
    read_enable_o <= 1'h0;
    read_addr_o <= ~a;
  endtask
endmodule // bre_fabric_model

// [testbench/bre_ecc_ram_tb.sv]
`timescale 1ns/10ps
module bre_ecc_ram_tb
  import bre_pkg::*;
();
  typedef struct packed {
    logic [2:0] wr;
    logic [2:0] rd;
    logic [63:0] d;
    logic [7:0] p1;
    logic [7:0] p2;
    logic s;
    logic db;
  } bre_row_t;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rdat;
  logic wb_ack_o, irq_o, write_enable_i, read_enable_i;
  logic [ADDR_W-1:0] write_addr_i, read_addr_i;
  logic [DATA_W-1:0] write_word_in_i, read_word_out_o;
  logic [CHECK_W-1:0] write_check_bits_in_i, generated_check_bits_out_o;
  logic [CHECK_W-1:0] read_check_bits_out_o;
  logic single_error_flag_o, double_error_flag_o;
  logic [71:0] flip, stored, expw;
  bre_row_t rows [7];
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  bre_ecc_ram uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .write_enable_i,
    .write_addr_i, .write_word_in_i, .write_check_bits_in_i,
    .generated_check_bits_out_o, .read_enable_i, .read_addr_i,
    .read_word_out_o, .read_check_bits_out_o, .single_error_flag_o,
    .double_error_flag_o);
  bre_fabric_model fab (.clk_i, .write_enable_o(write_enable_i),
    .write_addr_o(write_addr_i), .write_word_o(write_word_in_i),
    .write_check_o(write_check_bits_in_i), .read_enable_o(read_enable_i),
    .read_addr_o(read_addr_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ceiling far above the 150 or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk72(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the bench ceiling ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  function automatic logic [7:0] ref_check(input logic [63:0] d);
    logic [7:0] c;
    int n;
    c = 8'h00;
    n = 0;
    for (int q = 3; q < 72; q++) begin
      if ((q & (q - 1)) != 0) begin
        for (int k = 0; k < 7; k++) begin
          if (q[k]) c[k] = c[k] ^ d[n];
        end
        n++;
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{3'h1, 3'h1, 64'h0123456789ABCDEF, 8'hFF, 8'hFF, 1'h0, 1'h0},
      '{3'h2, 3'h3, 64'hFFFFFFFFFFFFFFFF, 8'h05, 8'hFF, 1'h1, 1'h0},
      '{3'h2, 3'h7, 64'h0, 8'h42, 8'hFF, 1'h1, 1'h0},
      '{3'h2, 3'h3, 64'h8000000000000001, 8'h00, 8'h3F, 1'h0, 1'h1},
      '{3'h2, 3'h7, 64'hDEADBEEF00C0FFEE, 8'h03, 8'h46, 1'h0, 1'h1},
      '{3'h3, 3'h0, 64'h5555AAAA5555AAAA, 8'hFF, 8'hFF, 1'h0, 1'h0},
      '{3'h2, 3'h5, 64'h00000000FFFF0000, 8'h0A, 8'hFF, 1'h0, 1'h0}};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      flip = '0;
      if (rows[i].p1 < 72) flip[rows[i].p1] = 1'h1;
      if (rows[i].p2 < 72) flip[rows[i].p2] = 1'h1;
      stored = {ref_check(rows[i].d), rows[i].d} ^ flip;
      wb(1'h1, OFS_CTRL, {29'h0, rows[i].wr});
      // Wrong check lines with encoder on: the stored code must be its own
      fab.write_word(9'(i), {rows[i].wr[0] ? ~stored[71:64] : stored[71:64],
        stored[63:0]});
      @(negedge clk_i);
      if (rows[i].wr[0]) begin
        chk32({24'h0, generated_check_bits_out_o},
          {24'h0, stored[71:64]});
      end
      expw = (rows[i].rd[1] && !rows[i].db) ? {ref_check(rows[i].d),
        rows[i].d} : stored;
      wb(1'h1, OFS_CTRL, {29'h0, rows[i].rd});
      fab.read_word(9'(i));
      if (rows[i].rd[2]) @(posedge clk_i);
      @(negedge clk_i);
      chk72({read_check_bits_out_o, read_word_out_o}, expw);
      chk32({30'h0, double_error_flag_o,
        single_error_flag_o}, {30'h0, rows[i].rd[1] ?
        {rows[i].db, rows[i].s} : 2'h0});
      $display("row %0d done", i);
    end
    wb(1'h0, OFS_STATUS, 32'h0);
    chk32(rdat, 32'h3);
    wb(1'h0, OFS_ERR_COUNT, 32'h0);
    chk32(rdat, 32'h00020002);
    wb(1'h0, OFS_ERR_ADDR, 32'h0);
    chk32(rdat, 32'h4);
    wb(1'h0, OFS_GEN_CHECK, 32'h0);
    chk32(rdat, {24'h0, ref_check(rows[5].d)});
    wb(1'h1, OFS_MASK, 32'h3);
    repeat (3) @(negedge clk_i);
    chk32({31'h0, irq_o}, 32'h1);
    wb(1'h1, OFS_MASK, 32'h0);
    repeat (3) @(negedge clk_i);
    chk32({31'h0, irq_o}, 32'h0);
    wb(1'h1, OFS_STATUS, 32'h3);
    wb(1'h0, OFS_STATUS, 32'h0);
    chk32(rdat, 32'h0);
    wb(1'h1, OFS_MASK, 32'h1);
    wb(1'h1, OFS_CTRL, 32'h3);
    fab.read_word(9'h001);
    repeat (3) @(negedge clk_i);
    chk32({31'h0, irq_o}, 32'h1);
    wb(1'h1, OFS_STATUS, 32'h1);
    repeat (3) @(negedge clk_i);
    chk32({31'h0, irq_o}, 32'h0);
    $display("interrupt test done");
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, OFS_CTRL, 32'h0);
    chk32(rdat, {29'h0, CTRL_RESET});
    wb(1'h0, OFS_MASK, 32'h0);
    chk32(rdat, 32'h0);
    wb(1'h0, 8'h18, 32'h0);
    chk32(rdat, 32'h0);
    chk72({read_check_bits_out_o, read_word_out_o}, 72'h0);
    chk32({29'h0, irq_o, double_error_flag_o, single_error_flag_o}, 32'h0);
    $display("reset test done");
    wrap_up();
  end
endmodule // bre_ecc_ram_tb
